// *** design/itxi_pkg.sv ***
// Constants for the transmit-context interrupt event and mask registers.
// Assumes a byte-addressed register port with 32-bit data.
package itxi_pkg;

  localparam int CTX_N = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Byte offsets
  localparam logic [7:0] OFS_EVENT_SET = 8'h90;
  localparam logic [7:0] OFS_EVENT_CLEAR = 8'h94;
  localparam logic [7:0] OFS_MASK_SET = 8'h98;
  localparam logic [7:0] OFS_MASK_CLEAR = 8'h9c;

  ////////////////////////////////////////////////////////////////////////////
  // Field layout: context bits in the low byte, the rest reserved
  localparam int CTX_LSB = 0;
  localparam int CTX_MSB = 7;
  localparam logic [23:0] RSVD_READ = 24'h000000;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values (left undefined by the hardware, zero here)
  localparam logic [7:0] EVENT_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;

endpackage : itxi_pkg

// *** design/itxi_edge.sv ***
// Rising-edge detector for the per-context interrupt signals.
// Assumes the inputs come from logic on the same clock.
`timescale 1ns/1ps

module itxi_edge (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] level_in,
  output logic [7:0] rise_out
);

  logic [7:0] prev_r;

  // Prev starts low, so a level already high at release counts as an edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_r <= 8'h00;
    end else begin
      prev_r <= level_in;
    end
  end

  assign rise_out = level_in & ~prev_r;

endmodule : itxi_edge

// *** design/itxi_regs.sv ***
// Transmit-context interrupt event and mask registers with set/clear
// addresses, plus the summary event and the gated interrupt output.
// Assumes DMA completion and interrupt-request signals on CLK_IN, and a
// register master that never issues read and write in the same cycle.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps

// Function
// - Completion with interrupt request raises context event
// - Event set on rising edge or set-write
// - Event cleared only by clear-address write
// - Clear-address read gives event AND mask
// - Bits 31 to 8 read zero, ignore writes
// - Event bit n belongs to context n
// - Summary feeds main event bit six
// - Mask zero blocks a context's contribution
// - Either mask address reads mask contents
// - Mask bit n gates event bit n
// - Interrupt needs summary event and main mask
module itxi_regs (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [7:0] CTX_DONE_IN,
  input wire logic [7:0] CTX_IRQ_REQ_IN,
  input wire logic MAIN_MASK_ISO_TX_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  output logic ISO_TX_SUMMARY_EVENT_OUT,
  output logic IRQ_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Context bits of a write to one address, zero otherwise
  function automatic logic [7:0] wr_bits(input logic [7:0] ofs,
                                         input logic wr,
                                         input logic [7:0] addr,
                                         input logic [31:0] wdata);
    if (wr && addr == ofs) begin
      return wdata[itxi_pkg::CTX_MSB:itxi_pkg::CTX_LSB];
    end else begin
      return 8'h00;
    end
  endfunction : wr_bits

  ////////////////////////////////////////////////////////////////////////////
  // Event sources

  logic [7:0] ctx_irq_w;
  logic [7:0] rise_w;
  logic [7:0] ev_r;
  logic [7:0] ev_nxt;
  logic [7:0] mask_r;
  logic [7:0] mask_nxt;
  logic [7:0] ev_set_w;
  logic [7:0] ev_clr_w;
  logic [7:0] mask_set_w;
  logic [7:0] mask_clr_w;
  logic [7:0] gated_w;
  logic [31:0] rdata_nxt;

  // Only a last-command completion that asked for an interrupt counts
  assign ctx_irq_w = CTX_DONE_IN & CTX_IRQ_REQ_IN;

  itxi_edge u_edge (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .level_in(ctx_irq_w),
    .rise_out(rise_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write decode; upper data bits never reach state

  assign ev_set_w = wr_bits(itxi_pkg::OFS_EVENT_SET, WR_IN, ADDR_IN,
                            WDATA_IN);
  assign ev_clr_w = wr_bits(itxi_pkg::OFS_EVENT_CLEAR, WR_IN, ADDR_IN,
                            WDATA_IN);
  assign mask_set_w = wr_bits(itxi_pkg::OFS_MASK_SET, WR_IN, ADDR_IN,
                              WDATA_IN);
  assign mask_clr_w = wr_bits(itxi_pkg::OFS_MASK_CLEAR, WR_IN, ADDR_IN,
                              WDATA_IN);

  ////////////////////////////////////////////////////////////////////////////
  // Event register

  // Set wins over a clear in the same cycle so no completion is lost
  assign ev_nxt = (ev_r & ~ev_clr_w) | rise_w | ev_set_w;

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ev_r <= itxi_pkg::EVENT_RESET;
    end else begin
      ev_r <= ev_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mask register

  assign mask_nxt = (mask_r | mask_set_w) & ~mask_clr_w;

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mask_r <= itxi_pkg::MASK_RESET;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Summary and interrupt

  assign gated_w = ev_r & mask_r;

  // Registered for a clean output; one cycle behind the event bits
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ISO_TX_SUMMARY_EVENT_OUT <= 1'b0;
      IRQ_OUT <= 1'b0;
    end else begin
      ISO_TX_SUMMARY_EVENT_OUT <= |gated_w;
      IRQ_OUT <= (|gated_w) & MAIN_MASK_ISO_TX_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; data stand only in the cycle after the strobe

  always_comb begin
    rdata_nxt = itxi_pkg::RDATA_RESET;
    if (RD_IN) begin
      unique case (ADDR_IN)
        itxi_pkg::OFS_EVENT_SET: begin
          rdata_nxt = {itxi_pkg::RSVD_READ, ev_r};
        end
        itxi_pkg::OFS_EVENT_CLEAR: begin
          rdata_nxt = {itxi_pkg::RSVD_READ, gated_w};
        end
        itxi_pkg::OFS_MASK_SET, itxi_pkg::OFS_MASK_CLEAR: begin
          rdata_nxt = {itxi_pkg::RSVD_READ, mask_r};
        end
        default: begin
          rdata_nxt = itxi_pkg::RDATA_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RDATA_OUT <= itxi_pkg::RDATA_RESET;
    end else begin
      RDATA_OUT <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  sequence ctx_rise_s;
    ##1 ctx_irq_w != 8'h00 && $past(ctx_irq_w) == 8'h00;
  endsequence

  sequence rd_at_s(logic [7:0] ofs);
    RD_IN && ADDR_IN == ofs;
  endsequence

  sequence wr_at_s(logic [7:0] ofs);
    WR_IN && ADDR_IN == ofs;
  endsequence

  // Context edge whose mask bit survives this cycle
  sequence gated_rise_s;
    (rise_w & mask_r & ~mask_clr_w) != 8'h00;
  endsequence

  ev_rise_a: assert property (
    (rise_w != 8'h00) |=> ((ev_r & $past(rise_w)) == $past(rise_w)))
    else $error("context edge did not set its event bit");

  ev_done_a: assert property (
    ctx_rise_s |=> ((ev_r & $past(ctx_irq_w)) == $past(ctx_irq_w)))
    else $error("requested completion did not raise event");

  ev_sticky_a: assert property (
    1'b1 |=> (($past(ev_r) & ~ev_r & ~$past(ev_clr_w)) == 8'h00))
    else $error("event bit fell without clear write");

  ev_clear_a: assert property (
    (ev_clr_w != 8'h00 && rise_w == 8'h00 && ev_set_w == 8'h00)
    |=> ((ev_r & $past(ev_clr_w)) == 8'h00))
    else $error("clear write left event bit set");

  rd_clear_a: assert property (
    rd_at_s(itxi_pkg::OFS_EVENT_CLEAR)
    |=> RDATA_OUT == {24'h000000, $past(ev_r & mask_r)})
    else $error("clear address read not event and mask");

  rd_set_a: assert property (
    rd_at_s(itxi_pkg::OFS_EVENT_SET)
    |=> RDATA_OUT == {24'h000000, $past(ev_r)})
    else $error("set address read not raw event");

  rsvd_zero_a: assert property (
    RDATA_OUT[31:8] == 24'h000000)
    else $error("reserved read bits not zero");

  rd_mask_a: assert property (
    (rd_at_s(itxi_pkg::OFS_MASK_SET) or rd_at_s(itxi_pkg::OFS_MASK_CLEAR))
    |=> RDATA_OUT == {24'h000000, $past(mask_r)})
    else $error("mask address read not mask contents");

  mask_set_a: assert property (
    (WR_IN && ADDR_IN == itxi_pkg::OFS_MASK_SET)
    |=> mask_r == ($past(mask_r) | $past(WDATA_IN[7:0])))
    else $error("mask set write wrong");

  mask_clr_a: assert property (
    (WR_IN && ADDR_IN == itxi_pkg::OFS_MASK_CLEAR)
    |=> mask_r == ($past(mask_r) & ~$past(WDATA_IN[7:0])))
    else $error("mask clear write wrong");

  summary_a: assert property (
    1'b1 |=> ISO_TX_SUMMARY_EVENT_OUT == (|($past(ev_r) & $past(mask_r))))
    else $error("summary event not or of gated bits");

  irq_gate_a: assert property (
    1'b1 |=> IRQ_OUT == ((|($past(ev_r) & $past(mask_r))) &&
                         $past(MAIN_MASK_ISO_TX_IN)))
    else $error("interrupt not summary and main mask");

  rd_idle_a: assert property (
    !RD_IN |=> RDATA_OUT == 32'h00000000)
    else $error("read data outside read reply cycle");

  ev_set_wr_a: assert property (
    wr_at_s(itxi_pkg::OFS_EVENT_SET)
    |=> (ev_r & $past(WDATA_IN[7:0])) == $past(WDATA_IN[7:0]))
    else $error("set address write did not set event bits");

  ev_cause_a: assert property (
    1'b1 |=> ((ev_r & ~$past(ev_r) & ~$past(ctx_irq_w)
               & ~$past(ev_set_w)) == 8'h00))
    else $error("event bit rose with no cause");

  set_wins_a: assert property (
    (ev_clr_w & (rise_w | ev_set_w)) != 8'h00
    |=> (ev_r & $past(ev_clr_w & (rise_w | ev_set_w)))
        == $past(ev_clr_w & (rise_w | ev_set_w)))
    else $error("same-cycle set lost to clear");

  ev_mask_wr_a: assert property (
    (WR_IN && ADDR_IN == itxi_pkg::OFS_MASK_SET && rise_w == 8'h00)
    |=> $stable(ev_r))
    else $error("mask write disturbed event bits");

  mask_hold_a: assert property (
    !(WR_IN && (ADDR_IN == itxi_pkg::OFS_MASK_SET ||
                ADDR_IN == itxi_pkg::OFS_MASK_CLEAR))
    |=> $stable(mask_r))
    else $error("mask changed without mask write");

  ////////////////////////////////////////////////////////////////////////////
  // Paths from an event to the outputs, and unmapped reads

  mask_gate_a: assert property (
    mask_r == 8'h00 |=> !ISO_TX_SUMMARY_EVENT_OUT)
    else $error("summary raised with all contexts masked");

  irq_off_a: assert property (
    !MAIN_MASK_ISO_TX_IN |=> !IRQ_OUT)
    else $error("interrupt raised with main mask clear");

  irq_summary_a: assert property (
    IRQ_OUT |-> ISO_TX_SUMMARY_EVENT_OUT)
    else $error("interrupt without summary event");

  rise_summary_a: assert property (
    gated_rise_s |=> ##1 ISO_TX_SUMMARY_EVENT_OUT)
    else $error("unmasked context event missed summary");

  summary_rise_a: assert property (
    $rose(ISO_TX_SUMMARY_EVENT_OUT) |-> $past((ev_r & mask_r) != 8'h00))
    else $error("summary rose with no unmasked event");

  rise_irq_a: assert property (
    gated_rise_s ##1 MAIN_MASK_ISO_TX_IN |=> IRQ_OUT)
    else $error("unmasked context event missed interrupt");

  rd_unmapped_a: assert property (
    (RD_IN && ADDR_IN != itxi_pkg::OFS_EVENT_SET &&
     ADDR_IN != itxi_pkg::OFS_EVENT_CLEAR &&
     ADDR_IN != itxi_pkg::OFS_MASK_SET &&
     ADDR_IN != itxi_pkg::OFS_MASK_CLEAR)
    |=> RDATA_OUT == 32'h00000000)
    else $error("unmapped read returned data");

endmodule : itxi_regs

// *** test/itxi_regs_tb.sv ***
// Self-checking bench for the transmit-context interrupt registers.
// Assumes itxi_pkg and itxi_regs are compiled first; one 40 MHz clock.
`timescale 1ns/1ps

module itxi_regs_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] done = 8'h00;
  logic [7:0] req = 8'h00;
  logic main_mask = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata;
  logic summary;
  logic irq;
  logic [31:0] d;
  logic [7:0] ev;
  int bad_count = 0;
  int samples_checked = 0;

  always #12.5 clk = ~clk;

  itxi_regs dut (.CLK_IN(clk), .RST_N_IN(rst_n), .CTX_DONE_IN(done),
    .CTX_IRQ_REQ_IN(req), .MAIN_MASK_ISO_TX_IN(main_mask), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr_en), .RD_IN(rd_en), .RDATA_OUT(rdata),
    .ISO_TX_SUMMARY_EVENT_OUT(summary), .IRQ_OUT(irq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("Counts: %0d checked, %0d bad", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  // Drives start on a rising edge; replies are read at the falling edge,
  // clear of the edge that launches them
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    v = rdata;
    @(negedge clk);
    check(rdata, 32'h00000000);
  endtask : bus_rd

  task automatic settle();
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic set_main(input logic v);
    @(posedge clk);
    main_mask <= v;
  endtask : set_main

  // Level drops for at least one edge before the next pulse
  task automatic pulse_ctx(input logic [7:0] dn, input logic [7:0] rq);
    @(posedge clk);
    done <= dn;
    req <= rq;
    @(posedge clk);
    done <= 8'h00;
    req <= 8'h00;
  endtask : pulse_ctx

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    foreach (ev[i]) begin
      bus_rd(8'h90 + 8'(i / 2 * 4), d);
      check(d, 32'h00000000);
    end
    check(32'(summary), 32'h0);
    $display("reset test done");
  endtask : t_reset

  task automatic t_mask();
    bus_wr(8'h98, 32'hffffff5a);
    bus_rd(8'h98, d);
    check(d, 32'h0000005a);
    bus_rd(8'h9c, d);
    check(d, 32'h0000005a);
    bus_wr(8'h9c, 32'hffffff0a);
    bus_rd(8'h98, d);
    check(d, 32'h00000050);
    bus_wr(8'ha0, 32'hffffffff);
    bus_rd(8'ha0, d);
    check(d, 32'h00000000);
    $display("mask test done");
  endtask : t_mask

  task automatic t_ctx();
    set_main(1'b1);
    pulse_ctx(8'hff, 8'h00);
    bus_rd(8'h90, d);
    check(d, 32'h00000000);
    ev = 8'h00;
    for (int n = 0; n < 8; n++) begin
      pulse_ctx(8'h01 << n, 8'hff);
      ev[n] = 1'b1;
      bus_rd(8'h90, d);
      check(d, {24'h000000, ev});
    end
    bus_rd(8'h94, d);
    check(d, 32'h00000050);
    settle();
    check(32'(summary), 32'h1);
    check(32'(irq), 32'h1);
    set_main(1'b0);
    settle();
    check(32'(irq), 32'h0);
    check(32'(summary), 32'h1);
    bus_wr(8'h94, 32'hffffff50);
    settle();
    check(32'(summary), 32'h0);
    bus_rd(8'h90, d);
    check(d, 32'h000000af);
    $display("context test done");
  endtask : t_ctx

  task automatic t_swset();
    @(posedge clk);
    done <= 8'h01;
    req <= 8'h01;
    repeat (2) @(posedge clk);
    bus_wr(8'h94, 32'h00000001);
    bus_rd(8'h90, d);
    check(d, 32'h000000ae);
    @(posedge clk);
    done <= 8'h00;
    req <= 8'h00;
    // Edge and clear of context 1 in one cycle: the set must win
    @(posedge clk);
    done <= 8'h02;
    req <= 8'h02;
    wr_en <= 1'b1;
    addr <= 8'h94;
    wdata <= 32'h00000002;
    @(posedge clk);
    wr_en <= 1'b0;
    done <= 8'h00;
    req <= 8'h00;
    bus_rd(8'h90, d);
    check(d, 32'h000000ae);
    bus_wr(8'h94, 32'hffffffff);
    bus_wr(8'h90, 32'hffffff81);
    bus_wr(8'h94, 32'h00000000);
    bus_rd(8'h90, d);
    check(d, 32'h00000081);
    bus_wr(8'h98, 32'h00000001);
    bus_rd(8'h94, d);
    check(d, 32'h00000001);
    set_main(1'b1);
    settle();
    check(32'(irq), 32'h1);
    $display("software set test done");
  endtask : t_swset

  task automatic t_rerun();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check(32'(irq), 32'h0);
    check(32'(summary), 32'h0);
    bus_rd(8'h90, d);
    check(d, 32'h00000000);
    bus_rd(8'h98, d);
    check(d, 32'h00000000);
    $display("mid-run reset test done");
  endtask : t_rerun

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_mask();
    t_ctx();
    t_swset();
    t_rerun();
    give_verdict();
  end

  // Cuts a hang short; counts as a mismatch
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    $display("BAD at %0t: run limit reached", $time);
    give_verdict();
  end
endmodule : itxi_regs_tb
